// *** design/socket_status_defs.vh ***
`ifndef SOCKET_STATUS_DEFS_VH
`define SOCKET_STATUS_DEFS_VH

// register word offsets (byte addresses in the memory window)
`define SKT_EVENT_OFS      8'h00
`define SKT_MASK_OFS       8'h04
`define SKT_PRESENT_OFS    8'h08
`define SKT_FORCE_OFS      8'h0C

// event and mask field positions
`define EV_STATUS_BIT      0
`define EV_DETECT1_BIT     1
`define EV_DETECT2_BIT     2
`define EV_POWER_BIT       3
`define EV_WIDTH           4

// present-state field positions
`define PS_POWERED_BIT     3
`define PS_WIDE_BUS_BIT    5
`define PS_CARD_IRQ_BIT    6
`define PS_UNDETERMINED_BIT 7
`define PS_REMOVED_BIT     8
`define PS_BAD_SUPPLY_BIT  9
`define PS_HIGH_VOLT_BIT   10
`define PS_LOW_VOLT_BIT    11

// supply capability constant in bits 31:28
`define PS_SUPPLY_CAP      4'h3

// reset values
`define EV_RESET           4'h0
`define MASK_RESET         4'h0
`define FLAGS_RESET        1'b0

`endif

// *** design/socket_status_event_regs.v ***
// Summary of operation
// [RL1] registers reached through a memory-space window
// [RL2] bus reset clears all event, mask, flags
// [RL3] write one clears event bit
// [RL4] force register write one sets event
// [RL5] after card reset, pending sources set events
// [RL6] event and mask bits 31:4 zero
// [RL7] power-up complete sets event bit 3
// [RL8] detect two change sets event bit 2
// [RL9] status-change assertion latches event bit 0
// [RL10] status interrupt from bit 0, wakeup; there is no wakeup path, bit 0 only feeds o_socket_irq
// [RL11] mask bit 3 gates power event
// [RL12] mask bits 2,1 gate detect events
// [RL13] mask bit 0 gates status change
// [RL14] supply capability bits read 0011
// [RL15] bit 11 flags low-voltage capable card
// [RL16] bit 10 flags high-voltage capable card
// [RL17] bit 9 flags bad supply request
// [RL18] bit 8 flags removal while active
// [RL19] bit 7 flags undetermined card
// [RL20] bit 6 mirrors card interrupt line
// [RL21] bit 5 flags wide-bus card
// [RL22] bits 27:12 reserved read zero
// [RL23] write-only force register at 0Ch
// [RL24] bit 3 shows socket power applied
// [RL25] detect one change sets event bit 1
// [RL26] irq while any masked event set
`timescale 1ns/1ps
`include "socket_status_defs.vh"

module socket_status_event_regs (
  input  wire        i_ref_clk,
  input  wire        i_rst_b,
  // register access port (memory window)
  input  wire        i_reg_sel,
  input  wire        i_reg_wr,
  input  wire [7:0]  i_reg_addr,
  input  wire [31:0] i_reg_wdata,
  output reg  [31:0] o_reg_rdata,
  // socket side pins (asynchronous)
  input  wire        i_card_status_chg,
  input  wire        i_card_detect_one_b,
  input  wire        i_card_detect_two_b,
  input  wire        i_card_irq_b,
  input  wire        i_card_reset_b,
  // internal socket engine indications (same clock)
  input  wire        i_power_cycle_done,
  input  wire        i_socket_powered,
  input  wire        i_socket_active,
  input  wire        i_card_low_volt,
  input  wire        i_card_high_volt,
  input  wire        i_card_wide_bus,
  input  wire        i_card_undetermined,
  input  wire        i_card_id_valid,
  input  wire        i_bad_supply_req,
  output reg         o_socket_irq
);

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers, one chain per pin: two flops, then a delayed copy
  // for edge detection; the first flop feeds nothing but the second
  localparam PIN_COUNT = 5;
  reg  [4:0] pin_meta_q;
  reg  [4:0] pin_sync_q;
  reg  [4:0] pin_prev_q;
  wire [4:0] pin_raw;
  genvar     pin_i;

  // pins turned active high: reset, irq, detect two, detect one, status
  assign pin_raw = {~i_card_reset_b, ~i_card_irq_b, ~i_card_detect_two_b,
                    ~i_card_detect_one_b, i_card_status_chg};

  generate
    for (pin_i = 0; pin_i < PIN_COUNT; pin_i = pin_i + 1) begin : g_pin
      always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
          pin_meta_q[pin_i] <= 1'b0;
          pin_sync_q[pin_i] <= 1'b0;
          pin_prev_q[pin_i] <= 1'b0;
        end else begin
          pin_meta_q[pin_i] <= pin_raw[pin_i];
          pin_sync_q[pin_i] <= pin_meta_q[pin_i];
          pin_prev_q[pin_i] <= pin_sync_q[pin_i];
        end
      end
    end
  endgenerate

  wire status_chg_lvl   = pin_sync_q[0];
  wire detect_one_lvl   = pin_sync_q[1];
  wire detect_two_lvl   = pin_sync_q[2];
  wire card_irq_lvl     = pin_sync_q[3];
  wire card_in_reset    = pin_sync_q[4];
  wire card_present     = detect_one_lvl | detect_two_lvl;

  //////////////////////////////////////////////////////////////////////////
  // settle counter: the delayed copy is valid only after three edges, so
  // pin edges are ignored until then; a card already seated at bus reset
  // would otherwise raise false events
  reg  [1:0] settle_q;
  wire       edges_ok = (settle_q == 2'h3);

  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      settle_q <= 2'h0;                                           // [RL2]
    end else if (!edges_ok) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  // pin edges seen by the event and flag logic
  wire status_rise      = edges_ok & status_chg_lvl & ~pin_prev_q[0];
  wire detect_one_edge  = edges_ok & (detect_one_lvl ^ pin_prev_q[1]);
  wire detect_two_edge  = edges_ok & (detect_two_lvl ^ pin_prev_q[2]);
  // a removal shows as detect one going inactive
  wire detect_one_fall  = edges_ok & pin_prev_q[1] & ~detect_one_lvl;

  // card reset release: pending sources raise their events
  wire reset_release    = edges_ok & pin_prev_q[4] & ~card_in_reset; // [RL5]

  //////////////////////////////////////////////////////////////////////////
  // register decode
  wire wr_event   = i_reg_sel & i_reg_wr & (i_reg_addr == `SKT_EVENT_OFS);
  wire wr_mask    = i_reg_sel & i_reg_wr & (i_reg_addr == `SKT_MASK_OFS);
  wire wr_force   = i_reg_sel & i_reg_wr &
                    (i_reg_addr == `SKT_FORCE_OFS);            // [RL23]

  // force fields; undetermined and wide-bus forces are refused while a card is seated,
  // the others always take effect
  wire [3:0] force_event = wr_force ? i_reg_wdata[3:0] : 4'h0;    // [RL4]
  wire force_low_volt    = wr_force & i_reg_wdata[`PS_LOW_VOLT_BIT];
  wire force_high_volt   = wr_force & i_reg_wdata[`PS_HIGH_VOLT_BIT];
  wire force_bad_supply  = wr_force & i_reg_wdata[`PS_BAD_SUPPLY_BIT];
  wire force_removed     = wr_force & i_reg_wdata[`PS_REMOVED_BIT];
  wire force_undet       = wr_force & ~card_present &
                           i_reg_wdata[`PS_UNDETERMINED_BIT];
  wire force_wide_bus    = wr_force & ~card_present &
                           i_reg_wdata[`PS_WIDE_BUS_BIT];

  //////////////////////////////////////////////////////////////////////////
  // event sources
  reg  [3:0] ev_set;

  always @* begin
    ev_set = 4'h0;
    // status change: assertion edge, and its level only at card reset release
    ev_set[`EV_STATUS_BIT]  = status_rise |
                              (reset_release & status_chg_lvl);   // [RL9]
    // detect changes in either direction
    ev_set[`EV_DETECT1_BIT] = detect_one_edge |
                              (reset_release & detect_one_lvl);   // [RL25]
    ev_set[`EV_DETECT2_BIT] = detect_two_edge |
                              (reset_release & detect_two_lvl);   // [RL8]
    // power-up completion pulse from the socket engine
    ev_set[`EV_POWER_BIT]   = i_power_cycle_done;                 // [RL7]
    // force writes set events as well
    ev_set = ev_set | force_event;                                // [RL4]
  end

  //////////////////////////////////////////////////////////////////////////
  // event register: set wins over write-one-to-clear, so an event that
  // lands in the cycle of the clearing write is kept
  localparam [3:0] EV_INIT = `EV_RESET;
  reg  [3:0] event_q;
  wire [3:0] event_clr = wr_event ? i_reg_wdata[3:0] : 4'h0;      // [RL3]
  wire [3:0] event_d   = (event_q & ~event_clr) | ev_set;
  genvar     ev_i;

  // one flop per event bit
  generate
    for (ev_i = 0; ev_i < `EV_WIDTH; ev_i = ev_i + 1) begin : g_event
      always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
          event_q[ev_i] <= EV_INIT[ev_i];                         // [RL2]
        end else begin
          event_q[ev_i] <= event_d[ev_i];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // mask register, upper bits not stored;
  // all enables are off after bus reset
  reg  [3:0] mask_q;

  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      mask_q <= `MASK_RESET;                                      // [RL2]
    end else if (wr_mask) begin
      mask_q <= i_reg_wdata[3:0];                                 // [RL6]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // present-state flags held in flops
  reg low_volt_card_capable_q;
  reg high_volt_card_capable_q;
  reg bad_supply_request_q;
  reg removed_while_active_q;
  reg undetermined_card_q;
  reg wide_bus_card_present_q;
  reg socket_powered_flag_q;

  // socket power flag follows the socket engine,
  // one cycle late
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      socket_powered_flag_q <= `FLAGS_RESET;                      // [RL2]
    end else begin
      socket_powered_flag_q <= i_socket_powered;                  // [RL24]
    end
  end

  // card type flags: loaded by identification, cleared once the socket
  // is empty, set by force writes; a force in the same cycle as a clear
  // wins, but while the socket is empty the forced flag is cleared again one cycle later
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      low_volt_card_capable_q  <= `FLAGS_RESET;                   // [RL2]
      high_volt_card_capable_q <= `FLAGS_RESET;
      undetermined_card_q      <= `FLAGS_RESET;
      wide_bus_card_present_q  <= `FLAGS_RESET;
    end else begin
      if (i_card_id_valid) begin
        low_volt_card_capable_q  <= i_card_low_volt;              // [RL15]
        high_volt_card_capable_q <= i_card_high_volt;             // [RL16]
        wide_bus_card_present_q  <= i_card_wide_bus;              // [RL21]
        undetermined_card_q      <= i_card_undetermined;          // [RL19]
      end else if (!card_present) begin
        low_volt_card_capable_q  <= 1'b0;
        high_volt_card_capable_q <= 1'b0;
        wide_bus_card_present_q  <= 1'b0;
        undetermined_card_q      <= 1'b0;
      end
      if (force_low_volt) begin
        low_volt_card_capable_q <= 1'b1;
      end
      if (force_high_volt) begin
        high_volt_card_capable_q <= 1'b1;
      end
      if (force_undet) begin
        undetermined_card_q <= 1'b1;
      end
      if (force_wide_bus) begin
        wide_bus_card_present_q <= 1'b1;
      end
    end
  end

  // bad supply request: sticky until the next card is identified;
  // a request in the cycle of identification keeps the flag
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      bad_supply_request_q <= `FLAGS_RESET;                       // [RL2]
    end else if (i_bad_supply_req || force_bad_supply) begin
      bad_supply_request_q <= 1'b1;                               // [RL17]
    end else if (i_card_id_valid) begin
      bad_supply_request_q <= 1'b0;
    end
  end

  // removal while the interface is active: sticky until the next card
  // is identified; removal and identification together keep the flag
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      removed_while_active_q <= `FLAGS_RESET;                     // [RL2]
    end else if ((i_socket_active && detect_one_fall) || force_removed) begin
      removed_while_active_q <= 1'b1;                             // [RL18]
    end else if (i_card_id_valid) begin
      removed_while_active_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // present-state word
  reg [31:0] present_word;

  always @* begin
    // reserved and future-voltage bits zero, supply capability fixed
    present_word = 32'h0000_0000;                                 // [RL22]
    present_word[31:28] = `PS_SUPPLY_CAP;                         // [RL14]
    // flags from the flops, interrupt bit live from its pin
    present_word[`PS_LOW_VOLT_BIT]     = low_volt_card_capable_q;
    present_word[`PS_HIGH_VOLT_BIT]    = high_volt_card_capable_q;
    present_word[`PS_BAD_SUPPLY_BIT]   = bad_supply_request_q;
    present_word[`PS_REMOVED_BIT]      = removed_while_active_q;
    present_word[`PS_UNDETERMINED_BIT] = undetermined_card_q;
    present_word[`PS_CARD_IRQ_BIT]     = card_irq_lvl;            // [RL20]
    present_word[`PS_WIDE_BUS_BIT]     = wide_bus_card_present_q;
    present_word[`PS_POWERED_BIT]      = socket_powered_flag_q;
  end

  //////////////////////////////////////////////////////////////////////////
  // read mux, registered; force register reads zero
  // read-back words: bits 31:4 are not stored, so they read zero and
  // writes to them are lost
  wire [31:0] event_word = {28'h0000000, event_q};
  wire [31:0] mask_word  = {28'h0000000, mask_q};
  reg  [31:0] rdata_d;

  always @* begin
    rdata_d = 32'h0000_0000;
    if (i_reg_sel && !i_reg_wr) begin
      // force register and unmapped offsets read zero
      case (i_reg_addr)
        `SKT_EVENT_OFS:   rdata_d = event_word;                   // [RL6]
        `SKT_MASK_OFS:    rdata_d = mask_word;                    // [RL1]
        `SKT_PRESENT_OFS: rdata_d = present_word;
        default:          rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // read data stands for one cycle, zero otherwise
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 32'h0000_0000;
    end else begin
      o_reg_rdata <= rdata_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // socket interrupt: any event with its enable
  wire [3:0] ev_irq   = event_d & mask_q;
  wire status_irq     = ev_irq[`EV_STATUS_BIT];                   // [RL13]
  wire detect_one_irq = ev_irq[`EV_DETECT1_BIT];                  // [RL12]
  wire detect_two_irq = ev_irq[`EV_DETECT2_BIT];                  // [RL12]
  wire power_irq      = ev_irq[`EV_POWER_BIT];                    // [RL11]
  wire irq_d = status_irq | detect_one_irq | detect_two_irq |
               power_irq;                                         // [RL26]

  // request registered so the pin comes straight from a flop
  always @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_socket_irq <= 1'b0;
    end else begin
      o_socket_irq <= irq_d;                        // [RL10] [RL11] [RL12] [RL13]
    end
  end

endmodule // socket_status_event_regs

// *** verif/card_socket_model.sv ***
`timescale 1ns/1ps
module card_socket_model (
  input  wire i_ref_clk,
  input  wire i_inserted,
  input  wire i_chg_req,
  input  wire i_irq_req,
  output reg  o_detect_one_b = 1'b1,
  output reg  o_detect_two_b = 1'b1,
  output wire o_status_chg,
  output wire o_irq_b
);
  // contacts mate one after the other; pulled up while empty
  always @(posedge i_ref_clk) begin
    o_detect_one_b <= #1 !i_inserted;
    o_detect_two_b <= #1 o_detect_one_b;
  end
  // an unseated card leaves both lines at their pull levels
  assign o_status_chg = i_chg_req && !o_detect_two_b;
  assign o_irq_b      = !(i_irq_req && !o_detect_two_b);
endmodule // card_socket_model

// *** verif/socket_status_event_regs_asserts.sv ***
`timescale 1ns/1ps
module socket_status_event_regs_asserts (
  input wire        i_ref_clk,
  input wire        i_rst_b,
  input wire        i_reg_sel,
  input wire        i_reg_wr,
  input wire [7:0]  i_reg_addr,
  input wire [31:0] i_reg_wdata,
  input wire [31:0] o_reg_rdata,
  input wire        i_card_status_chg,
  input wire        i_card_irq_b,
  input wire        o_socket_irq
);
  // decoded accesses
  wire        rd = i_reg_sel && !i_reg_wr;
  wire        wr = i_reg_sel && i_reg_wr;
  wire [7:0]  a  = i_reg_addr;
  wire [31:0] q  = o_reg_rdata;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  //////////////////////////////////////////////////////////////////////////
  rst_clear_a: assert property (disable iff (1'b0)
    !i_rst_b |=> !o_socket_irq && q == 32'h0) else $error("reset not clear");
  idle_zero_a: assert property (!rd |=> q == 32'h0)
    else $error("rdata not idle");
  force_zero_a: assert property (rd && a == 8'h0C |=> q == 32'h0)
    else $error("force readable");
  upper_zero_a: assert property (
    rd && a <= 8'h04 |=> q[31:4] == 28'h0) else $error("upper bits set");
  supply_cap_a: assert property (
    rd && a == 8'h08 |=> q[31:12] == 20'h30000) else $error("bad supply");
  card_irq_a: assert property (
    $stable(i_card_irq_b)[*5] ##0 rd && a == 8'h08
    |=> q[6] == !$past(i_card_irq_b)) else $error("card irq stale");
  w1c_a: assert property (
    (!i_card_status_chg)[*5] ##0 wr && a == 8'h00 && i_reg_wdata[0]
    ##1 !i_reg_sel ##1 rd && a == 8'h00 |=> !q[0]) else $error("no clear");
  latch_a: assert property (
    $rose(i_card_status_chg) ##1 (!i_reg_sel)[*4] ##1 rd && a == 8'h00
    |=> q[0]) else $error("status lost");
  mask_off_a: assert property (
    wr && a == 8'h04 && i_reg_wdata[3:0] == 4'h0 ##1 !i_reg_sel
    |=> !o_socket_irq) else $error("masked irq high");
endmodule // socket_status_event_regs_asserts
bind socket_status_event_regs socket_status_event_regs_asserts chk (.*);

// *** verif/socket_status_event_regs_test.sv ***
`timescale 1ns/1ps
module socket_status_event_regs_test;
  logic        i_ref_clk, i_rst_b, i_reg_sel, i_reg_wr, i_card_reset_b;
  logic        i_power_cycle_done, i_socket_powered, i_socket_active;
  logic        i_card_low_volt, i_card_high_volt, i_card_wide_bus;
  logic        i_card_undetermined, i_card_id_valid, i_bad_supply_req;
  logic        ins, chg, cirq;
  logic [7:0]  i_reg_addr;
  logic [31:0] i_reg_wdata;
  wire  [31:0] o_reg_rdata;
  wire         o_socket_irq, i_card_status_chg, i_card_irq_b;
  wire         i_card_detect_one_b, i_card_detect_two_b;
  int          checked, n_mismatch, cycles;
  typedef struct {logic [7:0] a; logic [31:0] d, m;} row_t;
  // mask of zero marks a write, else a masked read expecting d
  row_t rows [13] = '{'{8'h04, 32'h0, 32'hFFFFFFFF},
    '{8'h00, 32'h0, 32'hFFFFFFFF}, '{8'h08, 32'h30000000, 32'hFFFFFFFF},
    '{8'h04, 32'hFFFFFFFF, 32'h0}, '{8'h04, 32'hF, 32'hFFFFFFFF},
    '{8'h0C, 32'hF, 32'h0}, '{8'h00, 32'hF, 32'hFFFFFFFF},
    '{8'h00, 32'hFFFFFFF5, 32'h0}, '{8'h00, 32'hA, 32'hFFFFFFFF},
    '{8'h0C, 32'h0, 32'hFFFFFFFF}, '{8'h10, 32'h0, 32'hFFFFFFFF},
    '{8'h0C, 32'h300, 32'h0}, '{8'h08, 32'h30000300, 32'hFFFFFFFF}};
  socket_status_event_regs uut (.*);
  card_socket_model card (.i_ref_clk, .i_inserted(ins), .i_chg_req(chg),
    .i_irq_req(cirq), .o_detect_one_b(i_card_detect_one_b),
    .o_detect_two_b(i_card_detect_two_b),
    .o_status_chg(i_card_status_chg), .o_irq_b(i_card_irq_b));
  // clock and hang guard
  always #5 i_ref_clk = !i_ref_clk;
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_mismatch++;
      stop_test;
    end
  end
  task cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  task chk(input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // strobe stands for the taking edge only
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc(1);
    {i_reg_sel, i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, w, a, d};
    cyc(1);
    i_reg_sel = 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, e);
    acc(1'b0, a, 32'h0);
    chk(o_reg_rdata & m, e);
  endtask
  // write, then compare the interrupt request
  task wi(input logic [7:0] a, input logic [31:0] d, input logic e);
    acc(1'b1, a, d);
    cyc(1);
    chk({31'h0, o_socket_irq}, {31'h0, e});
  endtask
  task ident(input logic [3:0] f);
    {i_card_low_volt, i_card_high_volt, i_card_wide_bus,
      i_card_undetermined, i_card_id_valid} = {f, 1'b1};
    cyc(1);
    i_card_id_valid = 1'b0;
  endtask
  task stop_test;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {i_ref_clk, i_rst_b, i_reg_sel, i_reg_wr, i_power_cycle_done} = '0;
    {i_socket_powered, i_socket_active, i_card_id_valid, ins} = '0;
    {i_card_low_volt, i_card_high_volt, i_card_wide_bus, chg} = '0;
    {i_card_undetermined, i_bad_supply_req, cirq} = '0;
    {i_reg_addr, i_reg_wdata, i_card_reset_b} = {40'h0, 1'b1};
    cyc(5);
    i_rst_b = 1'b1;
    foreach (rows[i])
      if (rows[i].m == 32'h0) acc(1'b1, rows[i].a, rows[i].d);
      else rd(rows[i].a, rows[i].m, rows[i].d);
    chk({31'h0, o_socket_irq}, 32'h1);
    wi(8'h04, 32'h0, 1'b0);
    wi(8'h04, 32'h8, 1'b1);
    wi(8'h00, 32'hF, 1'b0);
    i_power_cycle_done = 1'b1;
    cyc(1);
    i_power_cycle_done = 1'b0;
    rd(8'h00, 32'hF, 32'h8);
    wi(8'h04, 32'h6, 1'b0);
    ins = 1'b1;
    cyc(8);
    rd(8'h00, 32'hF, 32'hE);
    chk({31'h0, o_socket_irq}, 32'h1);
    wi(8'h04, 32'h1, 1'b0);
    wi(8'h00, 32'hF, 1'b0);
    chg = 1'b1;
    cyc(4);
    chg = 1'b0;
    rd(8'h00, 32'hF, 32'h1);
    chk({31'h0, o_socket_irq}, 32'h1);
    wi(8'h00, 32'hF, 1'b0);
    i_card_reset_b = 1'b0;
    cyc(2);
    i_card_reset_b = 1'b1;
    cyc(6);
    rd(8'h00, 32'hF, 32'h6);
    {cirq, i_socket_powered} = 2'h3;
    cyc(3);
    ident(4'hE);
    rd(8'h08, 32'hFE8, 32'hC68);
    ident(4'h1);
    rd(8'h08, 32'hFA0, 32'h80);
    {i_socket_active, ins} = 2'b10;
    cyc(8);
    rd(8'h08, 32'h1A0, 32'h100);
    ins = 1'b1;
    i_bad_supply_req = 1'b1;
    cyc(1);
    i_bad_supply_req = 1'b0;
    cyc(8);
    acc(1'b1, 8'h0C, 32'hA0);
    rd(8'h08, 32'h3A0, 32'h300);
    wi(8'h04, 32'hF, 1'b1);
    i_rst_b = 1'b0;
    cyc(5);
    i_rst_b = 1'b1;
    chk({31'h0, o_socket_irq}, 32'h0);
    rd(8'h04, 32'hFFFFFFFF, 32'h0);
    rd(8'h00, 32'hFFFFFFFF, 32'h0);
    stop_test;
  end
endmodule // socket_status_event_regs_test
